// ### hdl/edt_dram_seq.sv
// fpm/edo dram cycle sequencer: read, write and cas-before-ras refresh
// assumes the graphics double clock is an unrelated pin clock and the
// request side is synchronous to sys_clk_in
`timescale 1ns/1ns
module edt_dram_seq (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic clk_sel_graphics_in,
  input wire logic graphics_double_clock_in,
  input wire logic [3:0] cfg_rcd_in,
  input wire logic [3:0] cfg_cas_in,
  input wire logic [3:0] cfg_rp_in,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic req_refresh_in,
  input wire logic [1:0] req_bank_in,
  input wire logic [11:0] req_row_in,
  input wire logic [11:0] req_col_in,
  input wire logic [7:0] req_byte_en_in,
  input wire logic [63:0] req_wdata_in,
  input wire logic [63:0] mem_data_bus_in,
  output logic req_ready_out,
  output logic rd_valid_out,
  output logic [63:0] rd_data_out,
  output logic [3:0] row_strobe_n_out,
  output logic [7:0] col_strobe_n_out,
  output logic [11:0] mux_address_bus_out,
  output logic mem_write_enable_n_out,
  output logic [63:0] mem_data_bus_out,
  output logic mem_data_bus_oe_n_out
);

  function automatic logic [3:0] at_least(
    input logic [3:0] val,
    input logic [3:0] floor
  );
    at_least = (val < floor) ? floor : val;
  endfunction : at_least

  logic rst_s1_ff;
  logic rst_s2_ff;
  logic rst_b;
  logic [2:0] gclk_sync_ff;
  logic gclk_lvl_ff;
  logic [3:0] div_ff;
  logic tick_ff;
  logic tick;
  edt_pkg::edt_state_t state_ff;
  edt_pkg::edt_state_t nxt_state;
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic [3:0] rc_cnt_ff;
  logic pend_ff;
  logic wr_ff;
  logic ref_ff;
  logic [1:0] bank_ff;
  logic [11:0] row_ff;
  logic [11:0] col_ff;
  logic [7:0] be_ff;
  logic [63:0] wdata_ff;
  logic accept;
  logic [3:0] rcd_eff;
  logic [3:0] cas_eff;
  logic [3:0] rp_eff;

  assign rst_b = rst_s2_ff;
  assign tick = tick_ff;
  assign accept = req_valid_in & req_ready_out;
  assign rcd_eff = at_least(cfg_rcd_in, edt_pkg::RCD_MIN_TICKS); // [RULE21]
  assign cas_eff = at_least(cfg_cas_in, edt_pkg::CAS_MIN_TICKS); // [RULE21]
  assign rp_eff = at_least(cfg_rp_in, edt_pkg::RP_MIN_TICKS); // [RULE21]

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end

  // pin clock is sampled; a level counts once stages two and three agree
  always_ff @(posedge sys_clk_in or negedge rst_b) begin
    if (!rst_b) begin
      gclk_sync_ff <= 3'h0;
      gclk_lvl_ff <= 1'b0;
    end else begin
      gclk_sync_ff <= {gclk_sync_ff[1:0], graphics_double_clock_in};
      if (gclk_sync_ff[1] == gclk_sync_ff[2]) begin
        gclk_lvl_ff <= gclk_sync_ff[2];
      end
    end
  end

  // one memory tick per selected clock period, all timing counts ticks
  always_ff @(posedge sys_clk_in or negedge rst_b) begin
    if (!rst_b) begin
      div_ff <= 4'h0;
      tick_ff <= 1'b0;
    end else begin
      if (div_ff >= edt_pkg::HOST_DIV_CYCLES - 4'h1) begin
        div_ff <= 4'h0;
      end else begin
        div_ff <= div_ff + 4'h1;
      end
      if (clk_sel_graphics_in) begin // [RULE1]
        tick_ff <= gclk_sync_ff[2] & gclk_sync_ff[1] & ~gclk_lvl_ff;
      end else begin
        tick_ff <= (div_ff >= edt_pkg::HOST_DIV_CYCLES - 4'h1);
      end
    end
  end

  // request latch; a taken request waits for the next tick
  always_ff @(posedge sys_clk_in or negedge rst_b) begin
    if (!rst_b) begin
      pend_ff <= 1'b0;
      wr_ff <= 1'b0;
      ref_ff <= 1'b0;
      bank_ff <= 2'h0;
      row_ff <= edt_pkg::ADDR_RST;
      col_ff <= edt_pkg::ADDR_RST;
      be_ff <= 8'h00;
      wdata_ff <= edt_pkg::DATA_RST;
    end else if (accept) begin
      pend_ff <= 1'b1;
      wr_ff <= req_write_in & ~req_refresh_in;
      ref_ff <= req_refresh_in;
      bank_ff <= req_bank_in;
      row_ff <= req_row_in;
      col_ff <= req_col_in;
      be_ff <= req_write_in ? req_byte_en_in : 8'hFF;
      wdata_ff <= req_wdata_in;
    end else if (tick && state_ff == edt_pkg::ST_IDLE &&
                 nxt_state != edt_pkg::ST_IDLE) begin
      pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b) begin
    if (!rst_b) begin
      req_ready_out <= 1'b0;
    end else begin
      req_ready_out <= ~pend_ff & ~accept &
                       (state_ff == edt_pkg::ST_IDLE);
    end
  end

  // ticks since the last cycle start, saturating at the cycle minimum
  always_ff @(posedge sys_clk_in or negedge rst_b) begin
    if (!rst_b) begin
      rc_cnt_ff <= edt_pkg::RC_MIN_TICKS;
    end else if (tick) begin
      if (state_ff == edt_pkg::ST_IDLE &&
          nxt_state != edt_pkg::ST_IDLE) begin
        rc_cnt_ff <= 4'h1;
      end else if (rc_cnt_ff < edt_pkg::RC_MIN_TICKS) begin
        rc_cnt_ff <= rc_cnt_ff + 4'h1;
      end
    end
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = (cnt_ff > 4'h1) ? cnt_ff - 4'h1 : 4'h1;
    case (state_ff)
      edt_pkg::ST_IDLE: begin
        if (pend_ff && rc_cnt_ff >= edt_pkg::RC_MIN_TICKS) begin // [RULE5]
          if (ref_ff) begin
            nxt_state = edt_pkg::ST_CBR_CAS;
            nxt_cnt = edt_pkg::CSR_TICKS; // [RULE17]
          end else begin
            nxt_state = edt_pkg::ST_ROW;
            nxt_cnt = 4'h1;
          end
        end
      end
      edt_pkg::ST_ROW: begin
        nxt_state = edt_pkg::ST_RAS;
        nxt_cnt = rcd_eff; // [RULE6] [RULE7]
      end
      edt_pkg::ST_RAS: begin
        if (cnt_ff == 4'h1) begin
          nxt_state = edt_pkg::ST_COL; // [RULE11]
          nxt_cnt = 4'h1;
        end
      end
      edt_pkg::ST_COL: begin
        nxt_state = edt_pkg::ST_CAS;
        nxt_cnt = cas_eff; // [RULE12] [RULE19]
      end
      edt_pkg::ST_CAS: begin
        if (cnt_ff == 4'h1) begin
          nxt_state = edt_pkg::ST_PRE; // [RULE3] [RULE4]
          nxt_cnt = rp_eff;
        end
      end
      edt_pkg::ST_CBR_CAS: begin
        if (cnt_ff == 4'h1) begin
          nxt_state = edt_pkg::ST_CBR_RAS;
          nxt_cnt = edt_pkg::CHR_TICKS; // [RULE18]
        end
      end
      edt_pkg::ST_CBR_RAS: begin
        if (cnt_ff == 4'h1) begin
          nxt_state = edt_pkg::ST_CBR_HOLD;
          nxt_cnt = edt_pkg::CBR_RAS_REST_TICKS;
        end
      end
      edt_pkg::ST_CBR_HOLD: begin
        if (cnt_ff == 4'h1) begin
          nxt_state = edt_pkg::ST_PRE;
          nxt_cnt = rp_eff;
        end
      end
      edt_pkg::ST_PRE: begin
        // precharge also keeps cas high after ras rises
        if (cnt_ff == 4'h1) begin
          nxt_state = edt_pkg::ST_IDLE; // [RULE16]
          nxt_cnt = 4'h1;
        end
      end
      default: begin
        nxt_state = edt_pkg::ST_IDLE;
        nxt_cnt = 4'h1;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= edt_pkg::ST_IDLE;
      cnt_ff <= 4'h1;
    end else if (tick) begin // [RULE21]
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  // strobes follow the next state so every pin changes on one tick
  always_ff @(posedge sys_clk_in or negedge rst_b) begin
    if (!rst_b) begin
      row_strobe_n_out <= edt_pkg::RAS_IDLE;
      col_strobe_n_out <= edt_pkg::CAS_IDLE;
    end else if (tick) begin
      case (nxt_state)
        edt_pkg::ST_RAS,
        edt_pkg::ST_COL: begin
          row_strobe_n_out <= ~(4'h1 << bank_ff);
          col_strobe_n_out <= edt_pkg::CAS_IDLE;
        end
        edt_pkg::ST_CAS: begin
          row_strobe_n_out <= ~(4'h1 << bank_ff); // [RULE10]
          col_strobe_n_out <= ~be_ff;
        end
        edt_pkg::ST_CBR_CAS: begin
          row_strobe_n_out <= edt_pkg::RAS_IDLE;
          col_strobe_n_out <= 8'h00; // [RULE17]
        end
        edt_pkg::ST_CBR_RAS: begin
          row_strobe_n_out <= 4'h0;
          col_strobe_n_out <= 8'h00; // [RULE18]
        end
        edt_pkg::ST_CBR_HOLD: begin
          row_strobe_n_out <= 4'h0;
          col_strobe_n_out <= edt_pkg::CAS_IDLE;
        end
        default: begin
          // after a read or write ras and cas rise together, well inside the one cycle limit; after refresh cas is already high
          row_strobe_n_out <= edt_pkg::RAS_IDLE; // [RULE3]
          col_strobe_n_out <= edt_pkg::CAS_IDLE;
        end
      endcase
    end
  end

  // row address stays through the ras tick, column through the cas pulse
  always_ff @(posedge sys_clk_in or negedge rst_b) begin
    if (!rst_b) begin
      mux_address_bus_out <= edt_pkg::ADDR_RST;
    end else if (tick) begin
      case (nxt_state)
        edt_pkg::ST_ROW: mux_address_bus_out <= row_ff;
        edt_pkg::ST_COL: mux_address_bus_out <= col_ff; // [RULE7] [RULE11]
        default: begin
          // held unchanged, covering the column hold past cas
          mux_address_bus_out <= mux_address_bus_out; // [RULE2]
        end
      endcase
    end
  end

  // write enable spans row to cas end, so its hold tracks cas width
  always_ff @(posedge sys_clk_in or negedge rst_b) begin
    if (!rst_b) begin
      mem_write_enable_n_out <= 1'b1;
    end else if (tick) begin
      case (nxt_state)
        edt_pkg::ST_ROW,
        edt_pkg::ST_RAS,
        edt_pkg::ST_COL,
        edt_pkg::ST_CAS: begin
          // reads keep it high the whole time [RULE8]
          mem_write_enable_n_out <= ~wr_ff; // [RULE9] [RULE13] [RULE14]
        end
        default: mem_write_enable_n_out <= 1'b1; // [RULE19]
      endcase
    end
  end

  // write data driven from row tick until precharge ends
  always_ff @(posedge sys_clk_in or negedge rst_b) begin
    if (!rst_b) begin
      mem_data_bus_out <= edt_pkg::DATA_RST;
      mem_data_bus_oe_n_out <= 1'b1;
    end else if (tick) begin
      if (nxt_state == edt_pkg::ST_ROW && wr_ff) begin
        mem_data_bus_out <= wdata_ff;
        mem_data_bus_oe_n_out <= 1'b0;
      end else if (nxt_state == edt_pkg::ST_IDLE) begin
        mem_data_bus_oe_n_out <= 1'b1; // [RULE15]
      end
    end
  end

  // read data sampled at the last tick of the programmed cas pulse
  always_ff @(posedge sys_clk_in or negedge rst_b) begin
    if (!rst_b) begin
      rd_valid_out <= 1'b0;
      rd_data_out <= edt_pkg::DATA_RST;
    end else begin
      rd_valid_out <= 1'b0;
      if (tick && state_ff == edt_pkg::ST_CAS &&
          nxt_state == edt_pkg::ST_PRE && !wr_ff) begin
        rd_valid_out <= 1'b1; // [RULE20]
        rd_data_out <= mem_data_bus_in;
      end
    end
  end

endmodule : edt_dram_seq

// ### hdl/edt_pkg.sv
// constants and state type for the fpm/edo dram cycle sequencer
// assumes a 250 MHz system clock; memory clock arrives as enables
// Notes on behaviour
// RULE1 - one selectable memory clock sequences all pins
// RULE2 - column address held one cycle past cas
// RULE3 - ras rises within one cycle of cas
// RULE4 - writes keep cas low before ras rises
// RULE5 - random cycles start six cycles apart minimum
// RULE6 - one cycle from ras low to cas low
// RULE7 - row address held one cycle past ras
// RULE8 - reads keep write enable high around cas
// RULE9 - writes assert write enable around cas
// RULE10 - column address valid one cycle from ras
// RULE11 - column address no earlier than ras plus one
// RULE12 - column address two cycles before ras rises
// RULE13 - write enable held one cycle versus ras
// RULE14 - write enable before ras and cas rise
// RULE15 - write data held three cycles versus ras
// RULE16 - one cycle from ras high to cas low
// RULE17 - refresh cas before ras, held after
// RULE18 - cas stays low one cycle past ras
// RULE19 - write enable hold follows cas pulse width
// RULE20 - read sample point scales with cas cycles
// RULE21 - tick counters enforce every minimum spacing
package edt_pkg;
  localparam int unsigned SYS_CLK_PS = 4000;
  localparam int unsigned HOST_CLK_PS = 15000;
  // host clock period rounded up to whole system cycles
  localparam logic [3:0] HOST_DIV_CYCLES =
    4'((HOST_CLK_PS + SYS_CLK_PS - 1) / SYS_CLK_PS);
  localparam logic [3:0] RC_MIN_TICKS = 4'h6;
  localparam logic [3:0] RCD_MIN_TICKS = 4'h1;
  localparam logic [3:0] CAS_MIN_TICKS = 4'h1;
  localparam logic [3:0] RP_MIN_TICKS = 4'h2;
  localparam logic [3:0] CSR_TICKS = 4'h1;
  localparam logic [3:0] CHR_TICKS = 4'h1;
  localparam logic [3:0] CBR_RAS_REST_TICKS = 4'h2;
  localparam logic [11:0] ADDR_RST = 12'h000;
  localparam logic [63:0] DATA_RST = 64'h0000_0000_0000_0000;
  localparam logic [3:0] RAS_IDLE = 4'hF;
  localparam logic [7:0] CAS_IDLE = 8'hFF;
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ROW,
    ST_RAS,
    ST_COL,
    ST_CAS,
    ST_PRE,
    ST_CBR_CAS,
    ST_CBR_RAS,
    ST_CBR_HOLD
  } edt_state_t;
endpackage : edt_pkg

// ### tb/edt_dram_seq_props.sv
// pin timing checker for the dram cycle sequencer
// assumes memory ticks come at least four system cycles apart
`timescale 1ns/1ns
module edt_dram_seq_props (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic [3:0] row_strobe_n_out,
  input wire logic [7:0] col_strobe_n_out,
  input wire logic [11:0] mux_address_bus_out,
  input wire logic mem_write_enable_n_out,
  input wire logic [63:0] mem_data_bus_out,
  input wire logic mem_data_bus_oe_n_out
);
  // one margin cycle for graphics tick jitter
  localparam int RC_MIN = 22;
  localparam int RAL_MIN = 7;
  logic [7:0] gap_ff;
  logic [7:0] age_ff;
  wire ras_lo = row_strobe_n_out != 4'hF;
  wire cas_lo = col_strobe_n_out != 8'hFF;
  wire we_n = mem_write_enable_n_out;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) gap_ff <= 8'hFF;
    else if ($fell(&row_strobe_n_out)) gap_ff <= 8'h00;
    else if (gap_ff != 8'hFF) gap_ff <= gap_ff + 8'h01;
  end
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) age_ff <= 8'hFF;
    else if ($changed(mux_address_bus_out)) age_ff <= 8'h00;
    else if (age_ff != 8'hFF) age_ff <= age_ff + 8'h01;
  end
  sequence s_cas_fall;
    $fell(&col_strobe_n_out) && ras_lo;
  endsequence
  sequence s_addr_hold;
    ##1 $stable(mux_address_bus_out)[*3];
  endsequence
  AST_RCD: assert property (s_cas_fall |-> $past(ras_lo, 3))
    else $error("cas fell too soon after ras");
  AST_RAH: assert property ($fell(&row_strobe_n_out) |-> s_addr_hold)
    else $error("row address moved too soon");
  AST_CAH: assert property (s_cas_fall |-> s_addr_hold)
    else $error("column address moved too soon");
  AST_CRW: assert property ($rose(&row_strobe_n_out) && !$past(we_n)
    |-> $past(cas_lo, 3) && !$past(we_n, 4)) else $error("write ras rise early");
  AST_RC: assert property ($fell(&row_strobe_n_out) |-> gap_ff >= RC_MIN)
    else $error("cycle start too close");
  AST_RCS: assert property (s_cas_fall ##0 we_n |-> $past(we_n, 3)
    ##1 we_n[*3]) else $error("read enable not held");
  AST_WCS: assert property (s_cas_fall ##0 !we_n |-> !$past(we_n, 3)
    ##1 (!we_n)[*3]) else $error("write enable not held");
  AST_RAL: assert property ($rose(&row_strobe_n_out) |-> age_ff >= RAL_MIN)
    else $error("column address late");
  AST_CSR: assert property ($fell(&row_strobe_n_out) && !cas_lo == 0
    && col_strobe_n_out == 8'h00 |-> $past(col_strobe_n_out, 3) == 8'h00
    ##1 (col_strobe_n_out == 8'h00)[*3]) else $error("refresh cas hold");
  AST_DHR: assert property ($fell(&row_strobe_n_out) && !we_n |->
    (!mem_data_bus_oe_n_out && $stable(mem_data_bus_out))[*8]
    ##4 !mem_data_bus_oe_n_out) else $error("write data hold");
endmodule : edt_dram_seq_props
bind edt_dram_seq edt_dram_seq_props edt_dram_seq_props_i (.sys_clk_in,
  .rst_b_in, .row_strobe_n_out, .col_strobe_n_out, .mux_address_bus_out,
  .mem_write_enable_n_out, .mem_data_bus_out, .mem_data_bus_oe_n_out);

// ### tb/edt_dram_model.sv
// dram module model: byte writes on cas fall, read data while cas low
// assumes strobes change just after rising edges of clk_in
`timescale 1ns/1ns
module edt_dram_model (
  input wire logic clk_in,
  input wire logic [3:0] row_n_in,
  input wire logic [7:0] col_n_in,
  input wire logic [11:0] addr_in,
  input wire logic we_n_in,
  input wire logic [63:0] data_in,
  output logic [63:0] data_out
);
  logic [63:0] mem [64];
  logic [63:0] last = 64'h0;
  logic [2:0] row_q = 3'h0;
  logic prev_ras = 1'h1;
  logic prev_cas = 1'h1;
  wire [5:0] key = {row_q, addr_in[2:0]};
  initial for (int i = 0; i < 64; i++) mem[i] = 64'h0;
  // released bus toggles so a stale sample cannot pass
  assign data_out = (col_n_in != 8'hFF && we_n_in) ? mem[key] : ~last;
  always @(posedge clk_in) begin
    last <= data_out;
    prev_ras <= &row_n_in;
    prev_cas <= &col_n_in;
    if (prev_ras && !(&row_n_in)) row_q <= addr_in[2:0];
    if (prev_cas && !(&col_n_in) && !(&row_n_in) && !we_n_in)
      for (int b = 0; b < 8; b++)
        if (!col_n_in[b]) mem[key][8*b +: 8] <= data_in[8*b +: 8];
  end
endmodule : edt_dram_model

// ### tb/edt_dram_seq_bench.sv
// self-checking bench for the dram cycle sequencer
// assumes host ticks every four system cycles
`timescale 1ns/1ns
module edt_dram_seq_bench;
  logic sys_clk_in = 1'h0;
  logic rst_b_in = 1'h0;
  logic clk_sel_graphics_in = 1'h0;
  logic graphics_double_clock_in = 1'h0;
  logic req_valid_in = 1'h0;
  logic req_write_in = 1'h0;
  logic req_refresh_in = 1'h0;
  logic [3:0] cfg_rcd_in = 4'h1;
  logic [3:0] cfg_cas_in = 4'h1;
  logic [3:0] cfg_rp_in = 4'h2;
  logic [1:0] req_bank_in = 2'h0;
  logic [11:0] req_row_in = 12'h000;
  logic [11:0] req_col_in = 12'h000;
  logic [7:0] req_byte_en_in = 8'hFF;
  logic [63:0] req_wdata_in = 64'h0;
  logic [63:0] mem_data_bus_in, rd_data_out, mem_data_bus_out;
  logic req_ready_out, rd_valid_out, mem_write_enable_n_out;
  logic mem_data_bus_oe_n_out;
  logic [3:0] row_strobe_n_out;
  logic [7:0] col_strobe_n_out;
  logic [11:0] mux_address_bus_out;
  logic [63:0] shadow [64];
  int err_count = 0;
  int checks_done = 0;
  always #2 sys_clk_in = ~sys_clk_in;
  always #11 graphics_double_clock_in = ~graphics_double_clock_in;
  edt_dram_seq edt_dram_seq_i (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .clk_sel_graphics_in(clk_sel_graphics_in),
    .graphics_double_clock_in(graphics_double_clock_in),
    .cfg_rcd_in(cfg_rcd_in),
    .cfg_cas_in(cfg_cas_in),
    .cfg_rp_in(cfg_rp_in),
    .req_valid_in(req_valid_in),
    .req_write_in(req_write_in),
    .req_refresh_in(req_refresh_in),
    .req_bank_in(req_bank_in),
    .req_row_in(req_row_in),
    .req_col_in(req_col_in),
    .req_byte_en_in(req_byte_en_in),
    .req_wdata_in(req_wdata_in),
    .mem_data_bus_in(mem_data_bus_in),
    .req_ready_out(req_ready_out),
    .rd_valid_out(rd_valid_out),
    .rd_data_out(rd_data_out),
    .row_strobe_n_out(row_strobe_n_out),
    .col_strobe_n_out(col_strobe_n_out),
    .mux_address_bus_out(mux_address_bus_out),
    .mem_write_enable_n_out(mem_write_enable_n_out),
    .mem_data_bus_out(mem_data_bus_out),
    .mem_data_bus_oe_n_out(mem_data_bus_oe_n_out)
  );
  edt_dram_model edt_dram_model_i (.clk_in(sys_clk_in),
    .row_n_in(row_strobe_n_out), .col_n_in(col_strobe_n_out),
    .addr_in(mux_address_bus_out), .we_n_in(mem_write_enable_n_out),
    .data_in(mem_data_bus_out), .data_out(mem_data_bus_in));
  task automatic chk(input string nm, input logic [63:0] e, g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  // one whole request; cl_exp of zero skips the pulse-length checks
  task automatic run(input logic wr, rf, input logic [1:0] bk,
      input logic [2:0] r, c, input logic [7:0] be, input logic [63:0] d,
      input int cl_exp);
    int n, rc, cl, rv;
    logic cbr;
    logic [3:0] rm;
    logic [63:0] e;
    e = shadow[{r, c}];
    for (int b = 0; b < 8; b++) if (wr && be[b]) e[8*b +: 8] = d[8*b +: 8];
    @(negedge sys_clk_in);
    req_valid_in = 1'h1;
    req_write_in = wr;
    req_refresh_in = rf;
    req_bank_in = bk;
    req_row_in = {9'h000, r};
    req_col_in = {9'h000, c};
    req_byte_en_in = be;
    req_wdata_in = d;
    for (n = 0; n < 99 && req_ready_out !== 1'h1; n++) @(negedge sys_clk_in);
    @(negedge sys_clk_in);
    req_valid_in = 1'h0;
    rc = 0;
    cl = 0;
    rv = 0;
    cbr = 1'h0;
    rm = 4'h0;
    for (n = 0; n < 200 && req_ready_out !== 1'h1; n++) begin
      if (row_strobe_n_out != 4'hF && col_strobe_n_out == 8'hFF &&
          cl == 0) rc++;
      if (col_strobe_n_out != 8'hFF) cl++;
      if (col_strobe_n_out == 8'h00 && row_strobe_n_out == 4'hF) cbr = 1'h1;
      rm = rm | ~row_strobe_n_out;
      if (rd_valid_out === 1'h1) begin
        rv++;
        chk("rd_data", e, rd_data_out);
      end
      @(negedge sys_clk_in);
    end
    shadow[{r, c}] = e;
    chk("idle", 1'h1, req_ready_out);
    chk("ras_sel", rf ? 4'hF : 4'h1 << bk, rm);
    if (rf) chk("cbr", 1'h1, cbr);
    else if (!wr) chk("rd_pulse", 1, rv);
    if (cl_exp > 0) chk("cas_len", cl_exp, cl);
    if (cl_exp > 0) chk("rcd", 1'h1,
      rc >= 4 * (cfg_rcd_in ? cfg_rcd_in : 1));
  endtask : run
  task automatic t_basic;
    run(1'h1, 1'h0, 2'h0, 3'h1, 3'h2, 8'hFF,
      64'h0123_4567_89AB_CDEF, 4);
    run(1'h0, 1'h0, 2'h0, 3'h1, 3'h2, 8'hFF, 64'h0, 4);
  endtask : t_basic
  task automatic t_bytes;
    run(1'h1, 1'h0, 2'h1, 3'h1, 3'h2, 8'h0F,
      64'hFEDC_BA98_7654_3210, 4);
    run(1'h0, 1'h0, 2'h1, 3'h1, 3'h2, 8'hFF, 64'h0, 4);
  endtask : t_bytes
  // zero settings must act as the clamped minima
  task automatic t_cfg;
    logic [3:0] cs [3] = '{4'h0, 4'h3, 4'h2};
    for (int i = 0; i < 3; i++) begin
      @(negedge sys_clk_in);
      cfg_cas_in = cs[i];
      cfg_rcd_in = cs[2 - i];
      cfg_rp_in = cs[i];
      run(1'h1, 1'h0, 2'h2, 3'h3, 3'(i), 8'hFF,
        {16'(i), 48'h5A5A_A5A5_C3C3}, 4 * (cs[i] ? cs[i] : 1));
      run(1'h0, 1'h0, 2'h2, 3'h3, 3'(i), 8'hFF,
        64'h0, 4 * (cs[i] ? cs[i] : 1));
    end
  endtask : t_cfg
  task automatic t_refresh;
    run(1'h0, 1'h1, 2'h2, 3'h0, 3'h0, 8'hFF, 64'h0, 0);
    run(1'h0, 1'h0, 2'h0, 3'h1, 3'h2, 8'hFF, 64'h0, 0);
  endtask : t_refresh
  task automatic t_graphics;
    @(negedge sys_clk_in);
    clk_sel_graphics_in = 1'h1;
    run(1'h1, 1'h0, 2'h3, 3'h5, 3'h6, 8'hF0,
      64'h1111_2222_3333_4444, 0);
    run(1'h0, 1'h0, 2'h3, 3'h5, 3'h6, 8'hFF, 64'h0, 0);
    clk_sel_graphics_in = 1'h0;
  endtask : t_graphics
  initial begin
    for (int i = 0; i < 64; i++) shadow[i] = 64'h0;
    repeat (5) @(posedge sys_clk_in);
    // look off the edge so the reset values have settled
    @(negedge sys_clk_in);
    chk("ras_rst", 4'hF, row_strobe_n_out);
    chk("cas_rst", 8'hFF, col_strobe_n_out);
    chk("oe_rst", 1'h1, mem_data_bus_oe_n_out);
    rst_b_in = 1'h1;
    t_basic;
    t_bytes;
    t_cfg;
    t_refresh;
    t_graphics;
    end_sim;
  end
  initial begin
    #100000;
    err_count++;
    end_sim;
  end
endmodule : edt_dram_seq_bench
